//--- rtl/crbs_pkg.sv
// Package: register map, field layout and carrier types for the receive buffer status block
// Function
// RQ1: Store into buffer sets its full flag
// RQ2: Writing zero clears flag, one leaves it
// RQ3: Store into full buffer sets overflow flag
// RQ4: Full flags split low/high sixteen-bit registers
// RQ5: Overflow flags split low/high sixteen-bit registers
// RQ6: Overflow clear means no overrun since clear
// RQ7: Only accepted, error-free stores update flags
// RQ8: Thirty-two buffers, indices zero to thirty-one
// RQ9: Hardware set wins over same-cycle clear
package crbs_pkg;
  // Buffer count and register geometry
  localparam int          NUM_BUFFERS   = 32;
  localparam int          REG_WIDTH     = 16;
  localparam int          ADDR_WIDTH    = 4;
  localparam int          IDX_WIDTH     = 5;
  // Register offsets (word index)
  localparam logic [3:0]  OFF_FULL_LOW  = 4'h0;
  localparam logic [3:0]  OFF_FULL_HIGH = 4'h1;
  localparam logic [3:0]  OFF_OVF_LOW   = 4'h2;
  localparam logic [3:0]  OFF_OVF_HIGH  = 4'h3;
  localparam logic [3:0]  OFF_IRQ_STAT  = 4'h4;
  localparam logic [3:0]  OFF_IRQ_MASK  = 4'h5;
  // Reset values
  localparam logic [15:0] RST_FLAGS     = 16'h0000;
  localparam logic [1:0]  RST_IRQ       = 2'h0;
  // Interrupt status field positions
  localparam int          IRQ_STORE_BIT = 0;
  localparam int          IRQ_OVF_BIT   = 1;
  // Store event from the receive path
  typedef struct packed {
    logic                 valid;   // One-cycle store strobe
    logic                 accepted; // Passed error check and filter match
    logic [4:0]           index;   // Target buffer
  } crbs_store_t;
  // Software register request
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [3:0]           addr;
    logic [15:0]          wdata;
  } crbs_req_t;
endpackage : crbs_pkg

//--- rtl/crbs_rx_buffer_status.sv
// Receive buffer full/overflow status flags with register port and interrupt
`timescale 1ns/1ps
`default_nettype none
module crbs_rx_buffer_status
  import crbs_pkg::*;
(
  // Clock, reset and enable
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  // Store event from the receive path
  input  wire crbs_store_t i_store,
  // Register port
  input  wire crbs_req_t   i_req,
  output logic [15:0]      o_rdata,
  // Status outputs
  output logic [31:0]      o_full_flags,
  output logic [31:0]      o_ovf_flags,
  output logic             o_irq
);

  // Flag vectors, bit n belongs to buffer n
  logic [NUM_BUFFERS-1:0] full_flags;   // Buffer holds an unread message
  logic [NUM_BUFFERS-1:0] ovf_flags;    // Store hit an already full buffer
  logic [NUM_BUFFERS-1:0] set_full;     // Per-buffer set request
  logic [NUM_BUFFERS-1:0] set_ovf;      // Per-buffer overrun request
  logic [NUM_BUFFERS-1:0] clr_full;     // Software clear mask
  logic [NUM_BUFFERS-1:0] clr_ovf;      // Software clear mask
  logic [1:0]             irq_stat;     // Sticky event bits
  logic [1:0]             irq_mask;     // Interrupt enables
  logic                   store_ok;     // Qualified store this cycle
  logic                   any_ovf_set;  // Any overrun this cycle
  logic                   wr_full_lo;
  logic                   wr_full_hi;
  logic                   wr_ovf_lo;
  logic                   wr_ovf_hi;

  // Only error-free, filter-matched stores count
  assign store_ok = i_clk_en & i_store.valid & i_store.accepted; // RQ7

  // Write decodes for the flag registers
  assign wr_full_lo = i_clk_en & i_req.wr & (i_req.addr == OFF_FULL_LOW);
  assign wr_full_hi = i_clk_en & i_req.wr & (i_req.addr == OFF_FULL_HIGH);
  assign wr_ovf_lo  = i_clk_en & i_req.wr & (i_req.addr == OFF_OVF_LOW);
  assign wr_ovf_hi  = i_clk_en & i_req.wr & (i_req.addr == OFF_OVF_HIGH);

  // A zero written clears, a one is ignored, so software never sets
  assign clr_full = {wr_full_hi ? ~i_req.wdata : RST_FLAGS,
                     wr_full_lo ? ~i_req.wdata : RST_FLAGS}; // RQ2 RQ4
  assign clr_ovf  = {wr_ovf_hi ? ~i_req.wdata : RST_FLAGS,
                     wr_ovf_lo ? ~i_req.wdata : RST_FLAGS}; // RQ2 RQ5

  // Per-buffer flag logic, one slice per buffer index
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BUFFERS; gi++) begin : g_buf
      // Decode the store index to this buffer
      assign set_full[gi] = store_ok & (i_store.index == IDX_WIDTH'(gi)); // RQ1 RQ8
      // Overrun only when already full before this store
      assign set_ovf[gi]  = set_full[gi] & full_flags[gi]; // RQ3

      // Full flag; set has priority over a same-cycle clear
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          full_flags[gi] <= 1'b0;
        end else if (set_full[gi]) begin
          full_flags[gi] <= 1'b1; // RQ1 RQ9
        end else if (clr_full[gi]) begin
          full_flags[gi] <= 1'b0; // RQ2
        end
      end

      // Overflow flag; stays set until software clears it
      always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
          ovf_flags[gi] <= 1'b0; // RQ6
        end else if (set_ovf[gi]) begin
          ovf_flags[gi] <= 1'b1; // RQ3 RQ9
        end else if (clr_ovf[gi]) begin
          ovf_flags[gi] <= 1'b0; // RQ2 RQ6
        end
      end
    end
  endgenerate

  // Any overrun this cycle feeds the sticky status bit
  assign any_ovf_set = |set_ovf;

  // Interrupt status: write one to clear, hardware set wins
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat <= RST_IRQ;
    end else if (i_clk_en) begin
      irq_stat[IRQ_STORE_BIT] <= store_ok |
        (irq_stat[IRQ_STORE_BIT] &
         ~(i_req.wr & (i_req.addr == OFF_IRQ_STAT) & i_req.wdata[IRQ_STORE_BIT])); // RQ9
      irq_stat[IRQ_OVF_BIT] <= any_ovf_set |
        (irq_stat[IRQ_OVF_BIT] &
         ~(i_req.wr & (i_req.addr == OFF_IRQ_STAT) & i_req.wdata[IRQ_OVF_BIT])); // RQ9
    end
  end

  // Interrupt mask register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask <= RST_IRQ;
    end else if (i_clk_en && i_req.wr && i_req.addr == OFF_IRQ_MASK) begin
      irq_mask <= i_req.wdata[1:0];
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign o_irq = |(irq_stat & irq_mask);

  // Read data registered, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= RST_FLAGS;
    end else if (i_clk_en) begin
      if (!i_req.rd) begin
        o_rdata <= RST_FLAGS;
      end else if (i_req.addr == OFF_FULL_LOW) begin
        o_rdata <= full_flags[15:0]; // RQ4
      end else if (i_req.addr == OFF_FULL_HIGH) begin
        o_rdata <= full_flags[31:16]; // RQ4
      end else if (i_req.addr == OFF_OVF_LOW) begin
        o_rdata <= ovf_flags[15:0]; // RQ5
      end else if (i_req.addr == OFF_OVF_HIGH) begin
        o_rdata <= ovf_flags[31:16]; // RQ5
      end else if (i_req.addr == OFF_IRQ_STAT) begin
        o_rdata <= {14'h0000, irq_stat};
      end else if (i_req.addr == OFF_IRQ_MASK) begin
        o_rdata <= {14'h0000, irq_mask};
      end else begin
        o_rdata <= RST_FLAGS;
      end
    end
  end

  // Flag vectors straight from flip-flops
  assign o_full_flags = full_flags;
  assign o_ovf_flags  = ovf_flags;

  // Properties guarding the flag behaviour
  property p_store_sets_full;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      store_ok |=> full_flags[$past(i_store.index)];
  endproperty
  a_store_sets_full: assert property (p_store_sets_full) // RQ1
    else $error("store did not set full flag");

  property p_overrun_sets_ovf;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (store_ok && full_flags[i_store.index]) |=> ovf_flags[$past(i_store.index)];
  endproperty
  a_overrun_sets_ovf: assert property (p_overrun_sets_ovf) // RQ3
    else $error("overrun did not set overflow flag");

  property p_no_sw_set;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (!store_ok) |=> ((full_flags & ~$past(full_flags)) == '0);
  endproperty
  a_no_sw_set: assert property (p_no_sw_set) // RQ2
    else $error("full flag rose without store");

  property p_ovf_needs_cause;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (any_ovf_set == 1'b0) |=> ((ovf_flags & ~$past(ovf_flags)) == '0);
  endproperty
  a_ovf_needs_cause: assert property (p_ovf_needs_cause) // RQ6
    else $error("overflow flag rose without overrun");

  property p_reject_no_change;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_store.valid && !i_store.accepted && !i_req.wr)
        |=> ($stable(full_flags) && $stable(ovf_flags));
  endproperty
  a_reject_no_change: assert property (p_reject_no_change) // RQ7
    else $error("rejected store changed flags");

  property p_set_beats_clear;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (store_ok && wr_full_lo && !i_store.index[4] && !i_req.wdata[i_store.index[3:0]])
        |=> full_flags[$past(i_store.index)];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // RQ9
    else $error("clear beat hardware set");

  property p_clear_low_full;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_full_lo && !store_ok) |=> (full_flags[15:0] == ($past(full_flags[15:0]) & $past(i_req.wdata)));
  endproperty
  a_clear_low_full: assert property (p_clear_low_full) // RQ4
    else $error("low full register write wrong");

  property p_read_high_ovf;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_clk_en && i_req.rd && i_req.addr == OFF_OVF_HIGH) |=> (o_rdata == $past(ovf_flags[31:16]));
  endproperty
  a_read_high_ovf: assert property (p_read_high_ovf) // RQ5
    else $error("high overflow read wrong");

  // Register writes clear exactly the zero bits of the addressed word
  property p_clear_high_full;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_full_hi && !store_ok)
        |=> (full_flags[31:16] == ($past(full_flags[31:16]) & $past(i_req.wdata)));
  endproperty
  a_clear_high_full: assert property (p_clear_high_full) // RQ4
    else $error("high full register write wrong");

  property p_clear_low_ovf;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_ovf_lo && !any_ovf_set)
        |=> (ovf_flags[15:0] == ($past(ovf_flags[15:0]) & $past(i_req.wdata)));
  endproperty
  a_clear_low_ovf: assert property (p_clear_low_ovf) // RQ5
    else $error("low overflow register write wrong");

  property p_clear_high_ovf;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (wr_ovf_hi && !any_ovf_set)
        |=> (ovf_flags[31:16] == ($past(ovf_flags[31:16]) & $past(i_req.wdata)));
  endproperty
  a_clear_high_ovf: assert property (p_clear_high_ovf) // RQ5
    else $error("high overflow register write wrong");

  // Read data mirror the addressed word one cycle after the strobe
  property p_read_low_full;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_clk_en && i_req.rd && i_req.addr == OFF_FULL_LOW)
        |=> (o_rdata == $past(full_flags[15:0]));
  endproperty
  a_read_low_full: assert property (p_read_low_full) // RQ4
    else $error("low full read wrong");

  property p_read_high_full;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_clk_en && i_req.rd && i_req.addr == OFF_FULL_HIGH)
        |=> (o_rdata == $past(full_flags[31:16]));
  endproperty
  a_read_high_full: assert property (p_read_high_full) // RQ4
    else $error("high full read wrong");

  property p_read_low_ovf;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_clk_en && i_req.rd && i_req.addr == OFF_OVF_LOW)
        |=> (o_rdata == $past(ovf_flags[15:0]));
  endproperty
  a_read_low_ovf: assert property (p_read_low_ovf) // RQ5
    else $error("low overflow read wrong");

  property p_rdata_idle;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (i_clk_en && !i_req.rd) |=> (o_rdata == RST_FLAGS);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // RQ2
    else $error("read data not zero outside a read");

  // Flags fall only through a software clear of their own word
  property p_full_holds;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (!wr_full_lo && !wr_full_hi) |=> ((~full_flags & $past(full_flags)) == '0);
  endproperty
  a_full_holds: assert property (p_full_holds) // RQ2
    else $error("full flag fell without clear");

  property p_ovf_holds;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (!wr_ovf_lo && !wr_ovf_hi) |=> ((~ovf_flags & $past(ovf_flags)) == '0);
  endproperty
  a_ovf_holds: assert property (p_ovf_holds) // RQ6
    else $error("overflow flag fell without clear");

  // Sticky status follows every qualified store and overrun
  property p_store_irq;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      store_ok |=> irq_stat[IRQ_STORE_BIT];
  endproperty
  a_store_irq: assert property (p_store_irq) // RQ1
    else $error("store did not raise status bit");

  property p_ovf_irq;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      any_ovf_set |=> irq_stat[IRQ_OVF_BIT];
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) // RQ3
    else $error("overrun did not raise status bit");

  // A low clock enable freezes every flag and the read word
  property p_freeze;
    @(posedge i_clk_sys) disable iff (!i_resetn)
      (!i_clk_en) |=> ($stable(full_flags) && $stable(ovf_flags) && $stable(o_rdata));
  endproperty
  a_freeze: assert property (p_freeze) // RQ7
    else $error("state moved with clock enable low");

  // Main scenarios the bench is expected to reach
  c_store: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) store_ok);
  c_set_beats_clear: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
    store_ok && wr_full_lo);
  c_overrun: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) any_ovf_set);
  c_clear_full: cover property (@(posedge i_clk_sys) disable iff (!i_resetn)
    wr_full_hi ##1 (full_flags[31:16] == 16'h0000));
  c_irq: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_irq);

endmodule : crbs_rx_buffer_status
`default_nettype wire

//--- verif/crbs_rx_engine_model.sv
// Behavioural receive engine that issues buffer store events
`timescale 1ns/1ps
`default_nettype none
module crbs_rx_engine_model
  import crbs_pkg::*;
(
  // Commands from the bench
  input  wire logic       i_go,
  input  wire logic       i_acc,
  input  wire logic [4:0] i_idx,
  // Store event toward the block
  output var crbs_store_t o_store
);
  // Outside a store the side fields carry junk, so the block cannot lean on them
  assign o_store = '{valid: i_go, accepted: i_go ? i_acc : ~i_acc,
                     index: i_go ? i_idx : ~i_idx};
endmodule : crbs_rx_engine_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the receive buffer status block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crbs_pkg::*;
  logic        clk, rstn, en, go, acc, irq;
  logic [4:0]  idx;
  logic [15:0] rdata, q;
  logic [31:0] full, ovf, e_full, e_ovf, r;
  crbs_store_t st;
  crbs_req_t   req;
  int          n_mismatch, num_checks;
  crbs_rx_engine_model eng (.i_go(go), .i_acc(acc), .i_idx(idx), .o_store(st));
  crbs_rx_buffer_status uut (.i_clk_sys(clk), .i_resetn(rstn), .i_clk_en(en),
    .i_store(st), .i_req(req), .o_rdata(rdata), .o_full_flags(full),
    .o_ovf_flags(ovf), .o_irq(irq));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  // One bus cycle; read data is taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1 q = rdata;
  endtask : bus
  // Expected value of a flag register
  function automatic logic [15:0] exp_reg(input logic [1:0] a);
    logic [63:0] all;
    all = {e_ovf, e_full};
    return all[a*16 +: 16];
  endfunction : exp_reg
  // Store attempt; bench model of full and overflow follows it
  task automatic store(input logic [4:0] i, input logic a);
    @(posedge clk);
    go  <= 1'b1;
    acc <= a;
    idx <= i;
    @(posedge clk);
    go  <= 1'b0;
    #1;
    if (a) begin
      if (e_full[i]) e_ovf[i] = 1'b1;
      e_full[i] = 1'b1;
    end
  endtask : store
  // Clear write: zeros clear, ones leave the flag alone
  task automatic wrclr(input logic [1:0] a, input logic [15:0] d);
    logic [63:0] all;
    bus(1'b1, {2'b00, a}, d);
    all = {e_ovf, e_full};
    all[a*16 +: 16] = all[a*16 +: 16] & d;
    {e_ovf, e_full} = all;
  endtask : wrclr
  task automatic check_regs;
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, a[3:0], 16'h0000);
      check("flag register", q, exp_reg(a[1:0]));
    end
    check("full flags", full, e_full);
    check("overflow flags", ovf, e_ovf);
  endtask : check_regs
  initial begin
    rstn = 1'b0; en = 1'b1; go = 1'b0; acc = 1'b0; idx = 5'h00; req = '0;
    e_full = 32'h0000_0000; e_ovf = 32'h0000_0000;
    r = $urandom(32'h5afc);
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    check_regs;
    check("irq", irq, 32'h0000_0000);
    bus(1'b0, 4'h6, 16'h0000);
    check("unmapped read", q, 32'h0000_0000);
    $display("test reset done");
    // Edge buffers 0, 15, 16 and 31, each stored twice
    for (int j = 0; j < 4; j++) begin
      store({j[1], {4{j[0]}}}, 1'b1);
      store({j[1], {4{j[0]}}}, 1'b1);
    end
    check_regs;
    store(5'd5, 1'b0);
    check_regs;
    for (int a = 0; a < 4; a++) wrclr(a[1:0], 16'hffff);
    check_regs;
    $display("test corners done");
    // Clear of the low full word and store into buffer 3 on one edge
    @(posedge clk);
    go  <= 1'b1; acc <= 1'b1; idx <= 5'd3;
    req <= '{wr: 1'b1, rd: 1'b0, addr: OFF_FULL_LOW, wdata: 16'h0000};
    @(posedge clk);
    go  <= 1'b0; req <= '0;
    e_full[15:0] = 16'h0008;
    check_regs;
    // Frozen clock enable ignores a store
    @(posedge clk);
    en <= 1'b0; go <= 1'b1; acc <= 1'b1; idx <= 5'd9;
    @(posedge clk);
    en <= 1'b1; go <= 1'b0;
    check_regs;
    // Interrupt raised, cleared, masked
    bus(1'b0, OFF_IRQ_STAT, 16'h0000);
    check("irq status", q, 32'h0000_0003);
    bus(1'b1, OFF_IRQ_MASK, 16'h0003);
    check("irq", irq, 32'h0000_0001);
    bus(1'b0, OFF_IRQ_MASK, 16'h0000);
    check("irq mask", q, 32'h0000_0003);
    bus(1'b1, OFF_IRQ_STAT, 16'h0003);
    check("irq", irq, 32'h0000_0000);
    store(5'd7, 1'b1);
    check("irq", irq, 32'h0000_0001);
    bus(1'b1, OFF_IRQ_MASK, 16'h0000);
    check("irq", irq, 32'h0000_0000);
    $display("test interrupt done");
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      store(r[4:0], r[5]);
      if (r[7:6] == 2'b00) wrclr(r[9:8], r[31:16]);
      check_regs;
    end
    $display("test random done");
    end_of_test;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    n_mismatch++;
    end_of_test;
  end
endmodule : tb
`default_nettype wire
